//--- wsc_top.sv
// wake-up line manager with stop entry sequence checker and bus slave
`default_nettype none
module wsc_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [wsc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [15:0] wake_line,
    input wire logic nmi_pin,
    input wire logic cpu_ack,
    output logic stop_request,
    output logic clock_hold,
    output logic channel_d1_irq,
    output logic top_level_irq
);
    import wsc_pkg::*;

    typedef struct packed {
        logic [15:0] wl_meta_r;
        logic [15:0] wl_sync_r;
        logic [15:0] wl_prev_r;
        logic nmi_meta_r;
        logic nmi_sync_r;
        logic nmi_prev_r;
        logic ctrl_stop_r;
        logic ctrl_src_r;
        logic ctrl_wake_r;
        logic [15:0] mask_r;
        logic [15:0] pol_r;
        logic [15:0] pend_r;
        logic exit_r;
        logic tl_edge_r;
        logic tl_pend_r;
        logic tl_unmask_r;
        logic tl_en_r;
        logic gie_r;
        logic d1_mask_r;
        logic d1_pend_r;
        logic d1_line_r;
        wsc_seq_t seq_r;
        wsc_pwr_t pwr_r;
        logic [CNT_W-1:0] cnt_r;
        logic wait_r;
        logic [31:0] rdata_r;
        logic stop_req_r;
        logic hold_r;
        logic d1_irq_r;
        logic tl_irq_r;
    } wsc_state_t;

    wsc_state_t s;
    wsc_state_t n;

    logic [15:0] line_evt;
    logic [15:0] live;
    logic nmi_rise;
    logic wr;
    logic [IDX_W-1:0] idx;
    logic wr_ctrl;
    logic wr_pend;
    logic stop_wr;
    logic abort;
    logic entry_ok;
    logic d1_line;
    logic [31:0] rd_mux;

    // edges seen on the synchronised lines, polarity picks the edge
    assign line_evt = (s.pol_r & s.wl_sync_r & ~s.wl_prev_r)
                    | (~s.pol_r & ~s.wl_sync_r & s.wl_prev_r);
    assign nmi_rise = s.nmi_sync_r & ~s.nmi_prev_r;
    assign live = s.pend_r & s.mask_r;

    // bus decode: a write acts in the cycle waitrequest is low
    assign wr = avs_write & ~s.wait_r;
    assign idx = avs_address[ADDR_W-1:2];
    assign wr_ctrl = wr && (idx == IDX_CTRL);
    assign wr_pend = wr && ((idx == IDX_PEND_H) || (idx == IDX_PEND_L));
    assign stop_wr = avs_writedata[STOP_BIT];

    // any other register write, an ack or an event spoils the sequence
    assign abort = (wr && !wr_ctrl) || cpu_ack || nmi_rise
                 || (|(line_evt & s.mask_r));

    // entry gate; software preparation is expected but checked here
    assign entry_ok = ~s.nmi_sync_r & s.ctrl_wake_r & ~(|live)
                    & (|s.mask_r);

    // request line drops for one cycle on a pending write so that a
    // remaining unmasked bit gives a fresh edge afterwards
    assign d1_line = s.ctrl_src_r & (|live) & ~wr_pend;

    // read mux; unused bits and unmapped words read as zero
    always_comb begin
        rd_mux = '0;
        case (idx)
            IDX_CTRL: begin
                rd_mux[STOP_BIT] = s.ctrl_stop_r;
                rd_mux[SRC_BIT] = s.ctrl_src_r;
                rd_mux[WAKE_BIT] = s.ctrl_wake_r;
            end
            IDX_MASK_H: rd_mux[7:0] = s.mask_r[15:8];
            IDX_MASK_L: rd_mux[7:0] = s.mask_r[7:0];
            IDX_POL_H: rd_mux[7:0] = s.pol_r[15:8];
            IDX_POL_L: rd_mux[7:0] = s.pol_r[7:0];
            IDX_PEND_H: rd_mux[7:0] = s.pend_r[15:8];
            IDX_PEND_L: rd_mux[7:0] = s.pend_r[7:0];
            IDX_CPU: begin
                rd_mux[EXIT_BIT] = s.exit_r;
                rd_mux[TL_EDGE_BIT] = s.tl_edge_r;
                rd_mux[TL_PEND_BIT] = s.tl_pend_r;
                rd_mux[TL_UNMASK_BIT] = s.tl_unmask_r;
                rd_mux[TL_EN_BIT] = s.tl_en_r;
                rd_mux[GIE_BIT] = s.gie_r;
                rd_mux[D1_MASK_BIT] = s.d1_mask_r;
                rd_mux[D1_PEND_BIT] = s.d1_pend_r;
            end
            default: rd_mux = '0;
        endcase
    end

    // next state of the whole block
    always_comb begin
        n = s;
        // the core clock keeps sampling; only the cpu clock is held
        n.wl_meta_r = wake_line;
        n.wl_sync_r = s.wl_meta_r;
        n.wl_prev_r = s.wl_sync_r;
        n.nmi_meta_r = nmi_pin;
        n.nmi_sync_r = s.nmi_meta_r;
        n.nmi_prev_r = s.nmi_sync_r;

        // two-phase handshake: accept, then complete one cycle later
        if ((avs_read || avs_write) && s.wait_r) begin
            n.wait_r = 1'b0;
            n.rdata_r = rd_mux;
        end else if (!s.wait_r) begin
            n.wait_r = 1'b1;
        end

        // plain configuration writes
        if (wr && idx == IDX_MASK_H) n.mask_r[15:8] = avs_writedata[7:0];
        if (wr && idx == IDX_MASK_L) n.mask_r[7:0] = avs_writedata[7:0];
        if (wr && idx == IDX_POL_H) n.pol_r[15:8] = avs_writedata[7:0];
        if (wr && idx == IDX_POL_L) n.pol_r[7:0] = avs_writedata[7:0];

        // pending: software writes the value, a new edge still sets
        if (wr && idx == IDX_PEND_H) n.pend_r[15:8] = avs_writedata[7:0];
        if (wr && idx == IDX_PEND_L) n.pend_r[7:0] = avs_writedata[7:0];
        n.pend_r = n.pend_r | line_evt;

        // cpu-side bits; the unmaskable bit can only be set
        if (wr && idx == IDX_CPU) begin
            n.exit_r = s.exit_r & avs_writedata[EXIT_BIT];
            n.tl_edge_r = avs_writedata[TL_EDGE_BIT];
            n.tl_pend_r = avs_writedata[TL_PEND_BIT];
            n.tl_unmask_r = s.tl_unmask_r
                          | avs_writedata[TL_UNMASK_BIT];
            n.tl_en_r = avs_writedata[TL_EN_BIT];
            n.gie_r = avs_writedata[GIE_BIT];
            n.d1_mask_r = avs_writedata[D1_MASK_BIT];
            n.d1_pend_r = avs_writedata[D1_PEND_BIT];
        end
        // besides a software write, only a fresh rising nmi edge with the edge bit set raises the top pending bit
        if (nmi_rise && s.tl_edge_r) begin
            n.tl_pend_r = 1'b1;
        end
        // channel d1 is edge recognised
        n.d1_line_r = d1_line;
        if (d1_line && !s.d1_line_r) begin
            n.d1_pend_r = 1'b1;
        end

        // stop bit sequence checker
        if (s.seq_r != SEQ_IDLE && abort) begin
            n.seq_r = SEQ_IDLE;
            n.ctrl_stop_r = 1'b0;
        end else if (wr_ctrl) begin
            n.ctrl_src_r = avs_writedata[SRC_BIT];
            n.ctrl_wake_r = avs_writedata[WAKE_BIT];
            case (s.seq_r)
                SEQ_IDLE: begin
                    n.ctrl_stop_r = stop_wr;
                    n.seq_r = stop_wr ? SEQ_ONE : SEQ_IDLE;
                end
                SEQ_ONE: begin
                    n.ctrl_stop_r = stop_wr;
                    n.seq_r = stop_wr ? SEQ_ONE : SEQ_ZERO;
                end
                SEQ_ZERO: begin
                    n.seq_r = SEQ_IDLE;
                    if (stop_wr && entry_ok) begin
                        // nmi sampled low at the third write
                        n.ctrl_stop_r = 1'b1;
                        n.pwr_r = PW_STOP;
                    end else if (stop_wr && s.nmi_sync_r) begin
                        // filtered; stays running, flag untouched
                        n.ctrl_stop_r = 1'b1;
                    end else begin
                        n.ctrl_stop_r = 1'b0;
                    end
                end
                default: n.seq_r = SEQ_IDLE;
            endcase
        end

        // power state: stop, then wait out the oscillator restart
        case (s.pwr_r)
            PW_RUN: n.cnt_r = '0;
            PW_STOP: begin
                if (s.ctrl_wake_r && (|live)) begin
                    n.ctrl_stop_r = 1'b0;
                    n.exit_r = 1'b1;
                    n.pwr_r = PW_RESTART;
                end else if (nmi_rise) begin
                    n.exit_r = 1'b1;
                    n.pwr_r = PW_RESTART;
                end
            end
            PW_RESTART: begin
                if (s.cnt_r == RESTART_LAST) begin
                    n.pwr_r = PW_RUN;
                end else begin
                    n.cnt_r = s.cnt_r + 1'b1;
                end
            end
            default: n.pwr_r = PW_RUN;
        endcase

        // registered outputs
        n.stop_req_r = (n.pwr_r == PW_STOP);
        n.hold_r = (n.pwr_r != PW_RUN);
        n.d1_irq_r = s.d1_pend_r & s.d1_mask_r;
        n.tl_irq_r = s.tl_pend_r
                   & (s.tl_unmask_r | (s.tl_en_r & s.gie_r));
    end

    // state register; control register resets to zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
            s.wait_r <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign avs_readdata = s.rdata_r;
    assign avs_waitrequest = s.wait_r;
    assign stop_request = s.stop_req_r;
    assign clock_hold = s.hold_r;
    assign channel_d1_irq = s.d1_irq_r;
    assign top_level_irq = s.tl_irq_r;

    // checks on the sequence, wake paths and request lines
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic third_ok;
    assign third_ok = wr_ctrl && s.seq_r == SEQ_ZERO && stop_wr && !abort;

    // stop state and its output flop update on the same edge, so a line
    // event right after entry cannot make this check fire
    a_stop_entry: assert property (
        third_ok && entry_ok |=> s.pwr_r == PW_STOP && stop_request)
        else $error("correct sequence did not enter stop");

    a_nmi_high_filter: assert property (
        third_ok && !entry_ok && s.nmi_sync_r
        |=> s.ctrl_stop_r && s.pwr_r == PW_RUN
            && s.exit_r == $past(s.exit_r))
        else $error("nmi high third write handled wrong");

    a_run_no_stop: assert property (
        s.pwr_r == PW_RUN && !(wr_ctrl && s.seq_r == SEQ_ZERO)
        |=> s.pwr_r != PW_STOP)
        else $error("stop entered outside a third write");

    a_exit_sticky: assert property (
        s.exit_r && !(wr && idx == IDX_CPU && !avs_writedata[EXIT_BIT])
        |=> s.exit_r)
        else $error("stop exit flag lost without a clear");

    a_abort_clears: assert property (
        s.seq_r != SEQ_IDLE && abort
        |=> !s.ctrl_stop_r && s.seq_r == SEQ_IDLE && s.pwr_r == PW_RUN)
        else $error("broken sequence left stop state");

    a_line_wake: assert property (
        s.pwr_r == PW_STOP && s.ctrl_wake_r && (|live)
        |=> !s.ctrl_stop_r && s.exit_r ##1 clock_hold && !stop_request)
        else $error("unmasked line did not end stop");

    a_nmi_wake: assert property (
        s.pwr_r == PW_STOP && !(s.ctrl_wake_r && (|live)) && nmi_rise
        |=> s.ctrl_stop_r && s.exit_r && s.pwr_r == PW_RESTART)
        else $error("nmi wake lost stop bit or flag");

    a_restart_end: assert property (
        s.pwr_r == PW_RESTART && s.cnt_r == RESTART_LAST
        |=> s.pwr_r == PW_RUN ##1 !clock_hold)
        else $error("restart delay end wrong");

    a_masked_silent: assert property (
        s.pwr_r == PW_STOP && !(|live) && !nmi_rise |=> s.pwr_r == PW_STOP)
        else $error("stop left without unmasked event");

    // the request output lags the pending bit by one flop
    a_d1_edge: assert property (
        d1_line && !s.d1_line_r
        |=> s.d1_pend_r
        ##1 channel_d1_irq == $past(s.d1_mask_r))
        else $error("channel d1 edge not captured");

    a_tl_request: assert property (
        nmi_rise && s.tl_edge_r && s.tl_unmask_r
        |=> s.tl_pend_r ##1 top_level_irq)
        else $error("top level request missing");

    a_tl_gated: assert property (
        s.tl_pend_r && !s.tl_unmask_r && !(s.tl_en_r && s.gie_r)
        |=> !top_level_irq)
        else $error("top level request passed while gated");

    // a level held on a line must never set its pending bit again
    a_pend_no_edge: assert property (
        !(|line_evt) && !wr_pend |=> s.pend_r == $past(s.pend_r))
        else $error("pending bit changed without an edge or write");

    a_pend_capture: assert property (
        |line_evt |=> (s.pend_r & $past(line_evt)) == $past(line_evt))
        else $error("line edge not captured");

    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");

    c_stop_entered: cover property (third_ok && entry_ok);
    c_line_exit: cover property (s.pwr_r == PW_STOP && (|live));
    c_nmi_exit: cover property (s.pwr_r == PW_STOP && nmi_rise);
    c_seq_abort: cover property (s.seq_r == SEQ_ZERO && abort);
    c_d1_reedge: cover property (wr_pend && s.d1_line_r && (|live));
endmodule
`default_nettype wire

//--- wsc_pkg.sv
// constants, register map and state types for the wake-up stop control block
`default_nettype none
package wsc_pkg;
    localparam int ADDR_W = 10;
    localparam int IDX_W = 8;
    localparam logic [IDX_W-1:0] IDX_CPU = 8'hF0;
    localparam logic [IDX_W-1:0] IDX_CTRL = 8'hF9;
    localparam logic [IDX_W-1:0] IDX_MASK_H = 8'hFA;
    localparam logic [IDX_W-1:0] IDX_MASK_L = 8'hFB;
    localparam logic [IDX_W-1:0] IDX_POL_H = 8'hFC;
    localparam logic [IDX_W-1:0] IDX_POL_L = 8'hFD;
    localparam logic [IDX_W-1:0] IDX_PEND_H = 8'hFE;
    localparam logic [IDX_W-1:0] IDX_PEND_L = 8'hFF;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int STOP_BIT = 2;
    localparam int SRC_BIT = 1;
    localparam int WAKE_BIT = 0;
    localparam int EXIT_BIT = 0;
    localparam int TL_EDGE_BIT = 1;
    localparam int TL_PEND_BIT = 2;
    localparam int TL_UNMASK_BIT = 3;
    localparam int TL_EN_BIT = 4;
    localparam int GIE_BIT = 5;
    localparam int D1_MASK_BIT = 6;
    localparam int D1_PEND_BIT = 7;
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_RESTART_NS = 1000;
    localparam int RESTART_CYC =
        (OSC_RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] RESTART_LAST = CNT_W'(RESTART_CYC - 1);
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ONE = 2'b01,
        SEQ_ZERO = 2'b10
    } wsc_seq_t;
    typedef enum logic [1:0] {
        PW_RUN = 2'b00,
        PW_STOP = 2'b01,
        PW_RESTART = 2'b10
    } wsc_pwr_t;
endpackage
`default_nettype wire

//--- wsc_pins.sv
// pin-side partner: wake lines, nmi pin and cpu acknowledge
`default_nettype none
module wsc_pins (
    input wire logic clk_sys,
    input wire logic [15:0] line_cmd,
    input wire logic nmi_cmd,
    input wire logic top_level_irq,
    output logic [15:0] wake_line = 16'h0000,
    output logic nmi_pin = 1'b0,
    output logic cpu_ack = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic irq_q = 1'b0;
    // pins follow the bench one edge later; the cpu acks each new request
    // so an nmi edge inside a stop sequence lands as an acknowledged irq
    always @(posedge clk_sys) begin
        wake_line <= line_cmd;
        nmi_pin <= nmi_cmd;
        irq_q <= top_level_irq;
        cpu_ack <= top_level_irq & ~irq_q;
    end
endmodule
`default_nettype wire

//--- wakeup_stop_entry_control_tb.sv
// self-checking bench for the wake-up stop control block
`default_nettype none
module wakeup_stop_entry_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import wsc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] wake_line;
    logic [15:0] line_cmd = 16'h0000;
    logic nmi_pin;
    logic nmi_cmd = 1'b0;
    logic cpu_ack;
    logic stop_request;
    logic clock_hold;
    logic channel_d1_irq;
    logic top_level_irq;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;

    wsc_top u_dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .wake_line(wake_line),
        .nmi_pin(nmi_pin),
        .cpu_ack(cpu_ack),
        .stop_request(stop_request),
        .clock_hold(clock_hold),
        .channel_d1_irq(channel_d1_irq),
        .top_level_irq(top_level_irq)
    );
    wsc_pins u_pins (
        .clk_sys(clk_sys),
        .line_cmd(line_cmd),
        .nmi_cmd(nmi_cmd),
        .top_level_irq(top_level_irq),
        .wake_line(wake_line),
        .nmi_pin(nmi_pin),
        .cpu_ack(cpu_ack)
    );

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    task automatic finish_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // hang guard, well above the one to two thousand cycles the run needs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // bits 7:3 of the control register always read zero
    function automatic logic [7:0] ctrl_exp(input logic [7:0] w);
        return w & 8'h03;
    endfunction

    // one avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic we, input logic [7:0] idx,
        input logic [7:0] wd, output logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_write <= we;
        avs_read <= ~we;
        avs_writedata <= {24'h000000, wd};
        @(posedge clk_sys);
        // only the hang guard ends a wait that never answers
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        d = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    // upper 24 bits must read zero as well as the masked field
    task automatic rdc(input logic [7:0] idx, input logic [7:0] m,
        input logic [7:0] e);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, d);
        chk(d & {24'hFFFFFF, m}, {24'h000000, e});
    endtask

    function automatic logic out_sel(input int s);
        case (s)
            0: return stop_request;
            1: return clock_hold;
            2: return channel_d1_irq;
            default: return top_level_irq;
        endcase
    endfunction

    // sampled on the falling edge so registered outputs have settled
    task automatic wait_out(input int s, input logic v, input int lim,
        output int n);
        n = 0;
        @(negedge clk_sys);
        while (out_sel(s) !== v && n < lim) begin
            n++;
            @(negedge clk_sys);
        end
        chk({31'h0, out_sel(s)}, {31'h0, v});
    endtask

    task automatic hold_out(input int s, input logic v, input int lim);
        int k;
        k = 0;
        repeat (lim) begin
            @(negedge clk_sys);
            if (out_sel(s) !== v) k++;
        end
        chk(k, 0);
    endtask

    // software preparation ahead of a stop attempt
    task automatic prep(input logic [7:0] f0);
        wr(IDX_POL_L, 8'h01);
        line_cmd <= 16'h0000;
        repeat (8) @(posedge clk_sys);
        wr(IDX_MASK_H, 8'h00);
        wr(IDX_MASK_L, 8'h01);
        wr(IDX_PEND_H, 8'h00);
        wr(IDX_PEND_L, 8'h00);
        wr(IDX_CTRL, 8'h03);
        wr(IDX_CPU, f0);
    endtask

    // kind 1 nmi edge, 2 line edge, 3 nmi drop, 4 ends in 0, 5 wake off
    task automatic run_seq(input int kind, input logic [7:0] f0);
        logic [7:0] w;
        prep(f0);
        w = (kind == 5) ? 8'h06 : 8'h07;
        wr(IDX_CTRL, w);
        wr(IDX_CTRL, w & 8'hFB);
        if (kind == 1) nmi_cmd <= 1'b1;
        if (kind == 2) line_cmd[0] <= 1'b1;
        if (kind == 3) nmi_cmd <= 1'b0;
        repeat (8) @(posedge clk_sys);
        wr(IDX_CTRL, (kind == 4) ? (w & 8'hFB) : w);
    endtask

    // main sequence
    initial begin
        logic [31:0] s;
        int n;
        s = 32'h000010C5;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            rdc(8'hF0 + 8'(i), 8'hFF, 8'h00);
        end
        wr(8'h10, 8'hFF);
        rdc(8'h10, 8'hFF, 8'h00);
        for (int i = 0; i < 12; i++) begin
            s = lfsr(s);
            wr(IDX_MASK_H + 8'(i % 4), s[7:0]);
            rdc(IDX_MASK_H + 8'(i % 4), 8'hFF, s[7:0]);
            wr(IDX_CTRL, s[15:8] & 8'hFB);
            rdc(IDX_CTRL, 8'hFF, ctrl_exp(s[15:8]));
        end
        // clean entry, exit by a rising line edge
        run_seq(0, 8'h00);
        wait_out(0, 1'b1, 6, n);
        line_cmd[0] <= 1'b1;
        wait_out(0, 1'b0, 10, n);
        wait_out(1, 1'b0, 150, n);
        chk(n >= RESTART_CYC - 5 && n <= RESTART_CYC + 5, 1);
        rdc(IDX_CTRL, 8'h04, 8'h00);
        rdc(IDX_CPU, 8'h01, 8'h01);
        rdc(IDX_PEND_L, 8'h01, 8'h01);
        wr(IDX_PEND_L, 8'h00);
        repeat (10) @(posedge clk_sys);
        rdc(IDX_PEND_L, 8'h01, 8'h00);
        // exit by nmi keeps the stop bit
        run_seq(0, 8'h00);
        wait_out(0, 1'b1, 6, n);
        nmi_cmd <= 1'b1;
        wait_out(1, 1'b0, 150, n);
        rdc(IDX_CTRL, 8'h04, 8'h04);
        rdc(IDX_CPU, 8'h01, 8'h01);
        // nmi still high at the third write
        run_seq(0, 8'h00);
        hold_out(0, 1'b0, 10);
        rdc(IDX_CTRL, 8'h04, 8'h04);
        rdc(IDX_CPU, 8'h01, 8'h00);
        nmi_cmd <= 1'b0;
        hold_out(0, 1'b0, 20);
        for (int i = 0; i < 2; i++) begin
            nmi_cmd <= i[0];
            run_seq(4, 8'h00);
            hold_out(0, 1'b0, 10);
            rdc(IDX_CTRL, 8'h04, 8'h00);
            rdc(IDX_CPU, 8'h01, 8'h00);
        end
        run_seq(3, 8'h00);
        wait_out(0, 1'b1, 6, n);
        line_cmd[0] <= 1'b1;
        wait_out(1, 1'b0, 150, n);
        run_seq(5, 8'h00);
        hold_out(0, 1'b0, 10);
        rdc(IDX_CTRL, 8'h07, 8'h02);
        for (int i = 0; i < 2; i++) begin
            run_seq(2, i[0] ? 8'h20 : 8'h00);
            hold_out(0, 1'b0, 10);
            rdc(IDX_CPU, 8'h01, 8'h00);
            rdc(IDX_PEND_L, 8'h01, 8'h01);
        end
        // channel d1: two edges at once, then clear one of them
        prep(8'h40);
        wr(IDX_CTRL, 8'h02);
        wr(IDX_MASK_L, 8'h03);
        line_cmd <= 16'h0002;
        repeat (8) @(posedge clk_sys);
        wr(IDX_PEND_L, 8'h00);
        line_cmd <= 16'h0001;
        wait_out(2, 1'b1, 12, n);
        rdc(IDX_PEND_L, 8'h03, 8'h03);
        rdc(IDX_CPU, 8'h80, 8'h80);
        wr(IDX_CPU, 8'h40);
        wait_out(2, 1'b0, 4, n);
        wr(IDX_PEND_L, 8'h02);
        wait_out(2, 1'b1, 6, n);
        rdc(IDX_CPU, 8'h80, 8'h80);
        wr(IDX_CPU, 8'h00);
        wr(IDX_PEND_H, 8'h00);
        wr(IDX_CPU, 8'h00);
        wr(IDX_PEND_L, 8'h00);
        rdc(IDX_CPU, 8'h80, 8'h00);
        wr(IDX_CPU, 8'h40);
        wr(IDX_POL_H, 8'h01);
        line_cmd <= 16'h0100;
        hold_out(2, 1'b0, 12);
        rdc(IDX_PEND_H, 8'h01, 8'h01);
        // top-level request through enable and gie, then unmaskable
        wr(IDX_CPU, 8'h32);
        nmi_cmd <= 1'b1;
        wait_out(3, 1'b1, 10, n);
        rdc(IDX_CPU, 8'h04, 8'h04);
        wr(IDX_CPU, 8'h32);
        wait_out(3, 1'b0, 4, n);
        hold_out(3, 1'b0, 20);
        nmi_cmd <= 1'b0;
        wr(IDX_CPU, 8'h0A);
        wr(IDX_CPU, 8'h02);
        rdc(IDX_CPU, 8'h08, 8'h08);
        nmi_cmd <= 1'b1;
        wait_out(3, 1'b1, 10, n);
        nmi_cmd <= 1'b0;
        // acknowledged nmi inside the sequence
        run_seq(1, 8'h0A);
        hold_out(0, 1'b0, 10);
        rdc(IDX_CPU, 8'h01, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
